// [pcat_tables.sv]
/*
 Three sets of eight address translation entries, register port, lookup and event status.
 Assumes lookup requests and events come from same-clock logic of the link core and interconnect.
*/
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module pcat_tables (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Register port
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// Lookup
	input pcat_pkg::pcat_req_s lookupReq,
	output pcat_pkg::pcat_rsp_s lookupRsp,
	// Translation events
	input pcat_pkg::pcat_evt_s event_i,
	output logic eventPending
);
	import pcat_pkg::*;

	logic [31:0] srcLo_q [NUM_SETS*NUM_ENTRIES];
	logic [31:0] srcHi_q [NUM_SETS*NUM_ENTRIES];
	logic [31:0] trsLo_q [NUM_SETS*NUM_ENTRIES];
	logic [31:0] trsHi_q [NUM_SETS*NUM_ENTRIES];
	logic [31:0] param_q [NUM_SETS*NUM_ENTRIES];
	logic [31:0] setStat_q [NUM_SETS];
	logic [NUM_SETS-1:0] localStat_q;
	logic [NUM_SETS-1:0] localMask_q;
	logic secure_q;
	logic [31:0] regRdata_q;
	pcat_rsp_s rsp_q;

	// Window mask from the size field; all ones above the window
	function automatic logic [63:0] winMask(input logic [5:0] sz);
		logic [6:0] bits;
		bits = {1'b0, sz} + 7'h01;
		winMask = (bits >= 7'h40) ? 64'h0 : (64'hffff_ffff_ffff_ffff << bits);
	endfunction

	function automatic pcat_entry_s entryOf(input int i);
		pcat_entry_s e;
		e.srcBase = {srcHi_q[i], srcLo_q[i][31:12], 12'h000};
		e.trsBase = {trsHi_q[i], trsLo_q[i][31:12], 12'h000};
		e.sizeField = srcLo_q[i][SIZE_LSB +: SIZE_W];
		e.enable = srcLo_q[i][0];
		e.attr = param_q[i][ATTR_LSB +: ATTR_W];
		e.target = param_q[i][TGT_W-1:0];
		return e;
	endfunction

	// Register decode
	wire [1:0] aSet = regAddr[SET_LSB +: 2];
	wire [2:0] aEnt = regAddr[ENT_LSB +: 3];
	wire [4:0] aWord = {regAddr[4:2], 2'b00};
	wire inTable = (aSet < 2'(NUM_SETS)) && (regAddr[9:8] == 2'b00);
	wire [4:0] aIdx = 5'(aSet * 8) + 5'(aEnt);
	wire fixedEntry = (aSet == 2'(SET_OUTB)) && (aEnt == 3'h0);
	wire tblWr = regWr && inTable && !fixedEntry;
	wire [63:0] rdMask = winMask(srcLo_q[aIdx][SIZE_LSB +: SIZE_W]);

	// Storage of the five stored words of every entry (mask words are computed), per-index generate
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SETS*NUM_ENTRIES; gi++) begin : g_ent
			localparam bit FIXED = (gi == SET_OUTB*NUM_ENTRIES);
			wire sel = tblWr && (aIdx == 5'(gi));
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) begin
					srcLo_q[gi] <= FIXED ? CFG_SRC_LO : RESET_WORD;
					srcHi_q[gi] <= RESET_WORD;
					trsLo_q[gi] <= RESET_WORD;
					trsHi_q[gi] <= RESET_WORD;
					param_q[gi] <= FIXED ? CFG_PARAM : RESET_WORD;
				end else if (sel) begin
					unique case (aWord)
						5'(OFS_SRC_LO): srcLo_q[gi] <= regWdata & SRC_LO_WMASK;
						5'(OFS_SRC_HI): srcHi_q[gi] <= regWdata;
						5'(OFS_TRS_LO): trsLo_q[gi] <= regWdata & TRS_LO_WMASK;
						5'(OFS_TRS_HI): trsHi_q[gi] <= regWdata;
						5'(OFS_PARAM): param_q[gi] <= regWdata & PARAM_WMASK;
						default: ;
					endcase
				end
			end
		end
	endgenerate

	// Read mux
	logic [31:0] tblData;
	always_comb begin
		unique case (aWord)
			5'(OFS_SRC_LO): tblData = srcLo_q[aIdx];
			5'(OFS_SRC_HI): tblData = srcHi_q[aIdx];
			5'(OFS_TRS_LO): tblData = trsLo_q[aIdx];
			5'(OFS_TRS_HI): tblData = trsHi_q[aIdx];
			5'(OFS_PARAM): tblData = param_q[aIdx];
			5'(OFS_MASK_LO): tblData = rdMask[31:0];
			5'(OFS_MASK_HI): tblData = rdMask[63:32];
			default: tblData = RESET_WORD;
		endcase
	end

	wire isSstat = (regAddr[11:4] == OFS_SSTAT0[11:4]) && (regAddr[3:2] < 2'(NUM_SETS));
	wire [31:0] rdNext = inTable ? tblData :
		isSstat ? setStat_q[regAddr[3:2]] :
		(regAddr == OFS_LSTAT) ? {29'h0, localStat_q} :
		(regAddr == OFS_LMASK) ? {29'h0, localMask_q} :
		(regAddr == OFS_SECURE) ? {31'h0, secure_q} : RESET_WORD;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) regRdata_q <= RESET_WORD;
		else regRdata_q <= regRd ? rdNext : RESET_WORD;
	end
	assign regRdata = regRdata_q;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			localMask_q <= '0;
			secure_q <= 1'b0;
		end else if (regWr) begin
			if (regAddr == OFS_LMASK) localMask_q <= regWdata[NUM_SETS-1:0];
			if (regAddr == OFS_SECURE) secure_q <= regWdata[0];
		end
	end

	// Event status: set wins over write-one-to-clear
	wire [31:0] evtBits = {28'h0, event_i.kind} << {event_i.entry, 2'b00};
	genvar gs;
	generate
		for (gs = 0; gs < NUM_SETS; gs++) begin : g_stat
			wire hitSet = event_i.valid && (event_i.set == 2'(gs));
			wire clr = regWr && isSstat && (regAddr[3:2] == 2'(gs));
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) setStat_q[gs] <= RESET_WORD;
				else setStat_q[gs] <= (setStat_q[gs] & ~(clr ? regWdata : 32'h0))
					| (hitSet ? evtBits : 32'h0);
			end
			always_ff @(posedge mclk or negedge rstn) begin
				if (!rstn) localStat_q[gs] <= 1'b0;
				else if (hitSet && localMask_q[gs]) localStat_q[gs] <= 1'b1;
				else if (regWr && regAddr == OFS_LSTAT && regWdata[gs])
					localStat_q[gs] <= 1'b0;
			end
		end
	endgenerate
	assign eventPending = |localStat_q;

	// Lookup: lowest matching enabled entry of the requested set wins
	logic hitAny;
	logic [2:0] hitIdx;
	pcat_entry_s hitEnt;
	always_comb begin
		pcat_entry_s e;
		e = '0;
		hitAny = 1'b0;
		hitIdx = 3'h0;
		hitEnt = '0;
		for (int k = NUM_ENTRIES-1; k >= 0; k--) begin
			e = entryOf(int'(lookupReq.set) * NUM_ENTRIES + k);
			if (lookupReq.set < 2'(NUM_SETS) && e.enable && e.sizeField >= SIZE_MIN
				&& ((lookupReq.addr & winMask(e.sizeField))
				== (e.srcBase & winMask(e.sizeField)))) begin
				hitAny = 1'b1;
				hitIdx = 3'(k);
				hitEnt = e;
			end
		end
	end

	wire [63:0] hMask = winMask(hitEnt.sizeField);
	wire [63:0] outAddr = (hitEnt.trsBase & hMask) | (lookupReq.addr & ~hMask);
	wire isAxi = hitEnt.target == TGT_AXI_M0;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) rsp_q <= '0;
		else begin
			rsp_q.valid <= lookupReq.valid;
			rsp_q.hit <= lookupReq.valid && hitAny;
			rsp_q.entry <= hitIdx;
			rsp_q.addr <= hitAny ? outAddr : lookupReq.addr;
			rsp_q.target <= hitEnt.target;
			rsp_q.tc <= isAxi ? 3'h0 : hitEnt.attr[10:8];
			rsp_q.ecrcFwd <= !isAxi && hitEnt.attr[7];
			rsp_q.poison <= !isAxi && hitEnt.attr[6];
			rsp_q.tlpAttr <= isAxi ? 2'h0 : hitEnt.attr[5:4];
			rsp_q.tlpType <= isAxi ? TLP_MEM : hitEnt.attr[2:0];
			rsp_q.axQos <= isAxi ? hitEnt.attr[11:8] : 4'h0;
			rsp_q.axProt <= isAxi ? {hitEnt.attr[7], secure_q, hitEnt.attr[5]} : 3'h0;
			rsp_q.axLock <= isAxi && hitEnt.attr[4];
			rsp_q.axCache <= isAxi ? hitEnt.attr[3:0] : 4'h0;
		end
	end
	assign lookupRsp = rsp_q;

	chk_fixed_entry_ro: assert property (@(posedge mclk) disable iff (!rstn)
		srcLo_q[SET_OUTB*NUM_ENTRIES] == CFG_SRC_LO) else $error("fixed entry changed");
	chk_rsvd_reads_zero: assert property (@(posedge mclk) disable iff (!rstn)
		regRd && inTable && aWord == 5'(OFS_RSVD) |=> regRdata == 32'h0)
		else $error("reserved word not zero");
	chk_read_one_cycle: assert property (@(posedge mclk) disable iff (!rstn)
		!regRd |=> regRdata == 32'h0) else $error("read data outside slot");
	chk_event_sticky: assert property (@(posedge mclk) disable iff (!rstn)
		event_i.valid && event_i.set < 2'(NUM_SETS) |=> (setStat_q[$past(event_i.set)]
		& $past(evtBits)) == $past(evtBits)) else $error("event lost");
	chk_local_masked: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(localStat_q[0]) |-> $past(localMask_q[0])) else $error("unmasked set");
	chk_miss_passthru: assert property (@(posedge mclk) disable iff (!rstn)
		lookupReq.valid && !hitAny |=> lookupRsp.valid && !lookupRsp.hit)
		else $error("false hit");
	chk_writable_entry: assert property (@(posedge mclk) disable iff (!rstn)
		regWr && inTable && !fixedEntry && aWord == 5'(OFS_SRC_HI) |=>
		srcHi_q[$past(aIdx)] == $past(regWdata)) else $error("write lost");
	chk_low_bits_rsvd: assert property (@(posedge mclk) disable iff (!rstn)
		inTable |-> trsLo_q[aIdx][11:0] == 12'h0 && srcLo_q[aIdx][11:7] == 5'h0)
		else $error("reserved bits set");
endmodule

// [pcat_pkg.sv]
/*
 Constants and carriers for the address translation tables of a root port bridge.
 Assumes a single 40 MHz clock domain and a plain strobe register port.
*/
package pcat_pkg;
	localparam int NUM_SETS = 3;
	localparam int NUM_ENTRIES = 8;
	localparam int SET_INB0 = 0;
	localparam int SET_INB1 = 1;
	localparam int SET_OUTB = 2;
	// Address map: [11:10] set, [7:5] entry, [4:2] word
	localparam logic [11:0] OFS_SRC_LO = 12'h0_000;
	localparam logic [11:0] OFS_SRC_HI = 12'h0_004;
	localparam logic [11:0] OFS_TRS_LO = 12'h0_008;
	localparam logic [11:0] OFS_TRS_HI = 12'h0_00c;
	localparam logic [11:0] OFS_PARAM = 12'h0_010;
	localparam logic [11:0] OFS_RSVD = 12'h0_014;
	localparam logic [11:0] OFS_MASK_LO = 12'h0_018;
	localparam logic [11:0] OFS_MASK_HI = 12'h0_01c;
	localparam logic [11:0] OFS_LSTAT = 12'h0_c00;
	localparam logic [11:0] OFS_LMASK = 12'h0_c04;
	localparam logic [11:0] OFS_SECURE = 12'h0_c08;
	localparam logic [11:0] OFS_SSTAT0 = 12'h0_c10;
	localparam int SET_LSB = 10;
	localparam int ENT_LSB = 5;
	localparam int WORD_LSB = 2;
	localparam int SIZE_LSB = 1;
	localparam int SIZE_W = 6;
	localparam logic [5:0] SIZE_MIN = 6'h0b;
	localparam int ATTR_LSB = 16;
	localparam int ATTR_W = 12;
	localparam int TGT_W = 4;
	localparam logic [31:0] SRC_LO_WMASK = 32'hffff_f07f;
	localparam logic [31:0] TRS_LO_WMASK = 32'hffff_f000;
	localparam logic [31:0] PARAM_WMASK = 32'h0fff_000f;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	// Fixed config entry: 4 KB window at 0x4000_0000 (size field 11, enabled)
	localparam logic [31:0] CFG_SRC_LO = 32'h4000_0017;
	localparam logic [31:0] CFG_PARAM = 32'h0000_0001;
	localparam int ST_OK = 3;
	localparam int ST_TMO = 2;
	localparam int ST_RDERR = 1;
	localparam int ST_WRERR = 0;
	localparam logic [2:0] TLP_MEM = 3'h0;
	localparam logic [2:0] TLP_MEMLK = 3'h1;
	localparam logic [2:0] TLP_IO = 3'h2;
	localparam logic [2:0] TLP_MSG = 3'h4;

	typedef enum logic [3:0] {
		TGT_PCIE_TXRX = 4'h0,
		TGT_PCIE_CFG = 4'h1,
		TGT_AXI_M0 = 4'h4
	} pcat_target_e;

	typedef struct packed {
		logic [63:0] srcBase;
		logic [63:0] trsBase;
		logic [5:0] sizeField;
		logic enable;
		logic [11:0] attr;
		logic [3:0] target;
	} pcat_entry_s;

	typedef struct packed {
		logic valid;
		logic [1:0] set;
		logic [63:0] addr;
	} pcat_req_s;

	typedef struct packed {
		logic valid;
		logic hit;
		logic [2:0] entry;
		logic [63:0] addr;
		logic [3:0] target;
		logic [2:0] tc;
		logic ecrcFwd;
		logic poison;
		logic [1:0] tlpAttr;
		logic [2:0] tlpType;
		logic [3:0] axQos;
		logic [2:0] axProt;
		logic axLock;
		logic [3:0] axCache;
	} pcat_rsp_s;

	typedef struct packed {
		logic valid;
		logic [1:0] set;
		logic [2:0] entry;
		logic [3:0] kind;
	} pcat_evt_s;
endpackage

// [pcat_far_end.sv]
/*
 Far-end requester: link core and interconnect issuing lookups and translation events.
 Assumes the bench calls its tasks from the mclk domain.
*/
`timescale 1ns/1ps
module pcat_far_end (
	// Clock
	input wire logic mclk,
	// Toward the tables
	output pcat_pkg::pcat_req_s lookupReq,
	output pcat_pkg::pcat_evt_s event_i
);
	import pcat_pkg::*;
	initial begin
		lookupReq = '0;
		event_i = '0;
	end
	// Released fields are inverted so a stale value is never mistaken for a live one
	task automatic lookup(input logic [1:0] s, input logic [63:0] a);
		@(posedge mclk);
		lookupReq <= '{1'b1, s, a};
		@(posedge mclk);
		lookupReq <= '{1'b0, ~s, ~a};
	endtask
	task automatic post(input logic [1:0] s, input logic [2:0] e, input logic [3:0] k);
		@(posedge mclk);
		event_i <= '{1'b1, s, e, k};
		@(posedge mclk);
		event_i <= '{1'b0, ~s, ~e, ~k};
	endtask
endmodule

// [pcie_address_translation_tables_bench.sv]
/*
 Self-checking bench: register, lookup and event results against a word model.
 Assumes one 40 MHz clock and the far-end requester module.
*/
`timescale 1ns/1ps
module pcie_address_translation_tables_bench;
	import pcat_pkg::*;
	logic mclk = 0, rstn = 0, regWr = 0, regRd = 0, sec = 0, eventPending;
	logic [11:0] regAddr = '0, ad;
	logic [31:0] regWdata = '0, regRdata, lst = '0, lmk = '0, d;
	logic [31:0] m [0:1023];
	logic [31:0] sst [0:2];
	logic [63:0] a;
	pcat_req_s lkReq;
	pcat_rsp_s lkRsp;
	pcat_evt_s evt;
	integer seed = 32'h7c9e, errCount = 0, checks = 0;
	pcat_tables DUT (.mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .lookupReq(lkReq),
		.lookupRsp(lkRsp), .event_i(evt), .eventPending(eventPending));
	pcat_far_end far (.mclk(mclk), .lookupReq(lkReq), .event_i(evt));
	initial forever #12.5 mclk = ~mclk;
	function automatic logic [31:0] wm(input logic [11:0] x);
		if (x[11:10] == 2'h3 || x[9:8] != 0 || x[11:5] == 7'h40)
			return '0;
		case (x[4:2])
			3'h0: return SRC_LO_WMASK;
			3'h1, 3'h3: return 32'hffff_ffff;
			3'h2: return TRS_LO_WMASK;
			3'h4: return PARAM_WMASK;
			default: return '0;
		endcase
	endfunction
	function automatic logic [31:0] er(input logic [11:0] x);
		logic [63:0] mk;
		mk = ~((64'h1 << (m[{x[11:5], 3'h0}][6:1] + 1)) - 1);
		if (x == OFS_LSTAT)
			return lst;
		if (x[11:4] == 8'hc1 && x[3:2] != 3)
			return sst[x[3:2]];
		if (x[11:10] == 2'h3)
			return '0;
		if (x[4:2] == 3'h6)
			return mk[31:0];
		if (x[4:2] == 3'h7)
			return mk[63:32];
		return m[x[11:2]];
	endfunction
	// Lowest enabled matching entry wins, so scan from the top down
	function automatic pcat_rsp_s el(input logic [1:0] s, input logic [63:0] x);
		pcat_rsp_s r;
		logic [63:0] mk, sb, tb;
		logic [31:0] p;
		int b;
		r = '0;
		r.valid = 1;
		r.addr = x;
		for (int e = 7; e >= 0; e--) begin
			b = s * 256 + e * 8;
			mk = ~((64'h1 << (m[b][6:1] + 1)) - 1);
			sb = {m[b + 1], m[b] & TRS_LO_WMASK};
			tb = {m[b + 3], m[b + 2]};
			p = m[b + 4];
			if (m[b][0] && m[b][6:1] >= SIZE_MIN && (x & mk) == (sb & mk)) begin
				r.hit = 1;
				r.entry = 3'(e);
				r.addr = (tb & mk) | (x & ~mk);
				r.target = p[3:0];
				{r.tc, r.ecrcFwd, r.poison, r.tlpAttr} = '0;
				r.tlpType = '0;
				{r.axQos, r.axProt, r.axLock, r.axCache} = '0;
				// Only the fields of the selected target's kind are carried
				if (p[3:0] == 4'h4) begin
					{r.axQos, r.axProt, r.axLock, r.axCache} = p[27:16];
					r.axProt[1] = sec;
				end else begin
					{r.tc, r.ecrcFwd, r.poison, r.tlpAttr} = p[26:20];
					r.tlpType = p[18:16];
				end
			end
		end
		return r;
	endfunction
	task automatic cmp_reg(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errCount++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cmp_lk(input pcat_rsp_s e, input pcat_rsp_s g);
		checks++;
		if (e.hit ? g !== e : {g.valid, g.hit, g.addr} !== {e.valid, e.hit, e.addr}) begin
			errCount++;
			$display("BAD lookupRsp exp %h got %h", e, g);
		end
	endtask
	task automatic wr(input logic [11:0] x, input logic [31:0] v);
		@(posedge mclk);
		regWr <= 1;
		regAddr <= x;
		regWdata <= v;
		@(posedge mclk);
		regWr <= 0;
		regWdata <= ~v;
		m[x[11:2]] = (m[x[11:2]] & ~wm(x)) | (v & wm(x));
		if (x == OFS_LMASK)
			lmk = v;
		if (x == OFS_SECURE)
			sec = v[0];
		if (x == OFS_LSTAT)
			lst &= ~v;
		if (x[11:4] == 8'hc1 && x[3:2] != 3)
			sst[x[3:2]] &= ~v;
	endtask
	task automatic rc(input logic [11:0] x);
		@(posedge mclk);
		regRd <= 1;
		regAddr <= x;
		@(posedge mclk);
		regRd <= 0;
		#1 cmp_reg("regRdata", er(x), regRdata);
	endtask
	task automatic lk(input logic [1:0] s, input logic [63:0] x);
		far.lookup(s, x);
		#1 cmp_lk(el(s, x), lkRsp);
	endtask
	task automatic ev(input logic [1:0] s, input logic [2:0] e, input logic [3:0] k);
		far.post(s, e, k);
		if (s < 3) begin
			sst[s] |= 32'(k) << (e * 4);
			if (lmk[s])
				lst[s] = 1;
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#(25 * 8000);
		errCount++;
		end_sim;
	end
	initial begin
		for (int i = 0; i < 1024; i++)
			m[i] = '0;
		m[10'h200] = CFG_SRC_LO;
		m[10'h204] = CFG_PARAM;
		sst = '{default: '0};
		repeat (5) @(posedge mclk);
		rstn <= 1;
		rc(12'h0_800);
		rc(12'h0_810);
		rc(12'h0_818);
		wr(12'h0_800, '0);
		rc(12'h0_800);
		wr(12'h0_014, 32'hffff_ffff);
		rc(12'h0_014);
		wr(12'h0_c40, 32'hffff_ffff);
		rc(12'h0_c40);
		$display("test fixed entry done");
		for (int i = 0; i < 40; i++) begin
			a = {$random(seed), $random(seed)};
			ad = {(a[0] ? 2'h1 : 2'h2), 2'h0, a[7:2], 2'h0};
			d = a[63:32];
			if (ad[4:2] == 0)
				d[6:1] = 6'(11 + a[13:8] % 53);
			if (ad[4:2] == 4 && d[3:0] == 4'h1)
				d[3:0] = 4'h0;
			wr(ad, d);
			rc(ad);
			rc({ad[11:5], 5'h18});
			rc({ad[11:5], 5'h1c});
			lk(ad[11:10], {m[{ad[11:5], 3'h1}], m[{ad[11:5], 3'h0}][31:12], a[19:8]});
		end
		$display("test random entries done");
		wr(12'h0_020, 32'h3456_7017);
		wr(12'h0_024, 32'h0000_0012);
		wr(12'h0_028, 32'h9abc_d000);
		wr(12'h0_02c, 32'h0000_0005);
		for (int i = 0; i < 6; i++) begin
			a = {$random(seed), $random(seed)};
			wr(OFS_SECURE, 32'(i % 2));
			d = {4'h0, a[8:0], (i == 3 ? 3'h4 : 3'(i % 4)), 12'h0, (i < 4 ? 4'(i % 2) : 4'h4)};
			wr(12'h0_030, d);
			lk(2'h0, {32'h12, 20'h3_4567, a[43:32]});
			lk(2'h0, {32'h12, 20'h3_4568, a[43:32]});
			lk(2'h1, {32'h12, 20'h3_4567, a[43:32]});
		end
		lk(2'h2, {32'h0, 20'h4_0000, a[11:0]});
		$display("test lookup done");
		for (int i = 0; i < 4; i++) begin
			ev(2'(i % 3), 3'(i * 2 + 1), 4'h1 << i);
			rc(OFS_SSTAT0 + 12'(4 * (i % 3)));
		end
		rc(OFS_LSTAT);
		cmp_reg("eventPending", 32'(lst != 0), 32'(eventPending));
		wr(OFS_LMASK, 32'h0000_0002);
		ev(2'h1, 3'h7, 4'h8);
		ev(2'h3, 3'h0, 4'hf);
		rc(OFS_LSTAT);
		rc(12'h0_c14);
		cmp_reg("eventPending", 32'(lst != 0), 32'(eventPending));
		wr(OFS_LSTAT, 32'h0000_0007);
		wr(12'h0_c14, 32'hffff_ffff);
		rc(OFS_LSTAT);
		rc(12'h0_c14);
		cmp_reg("eventPending", 32'(lst != 0), 32'(eventPending));
		$display("test events done");
		end_sim;
	end
endmodule
